/* friu_top.sv */
`timescale 1ns/100ps
`default_nettype none
module friu_top #(
  parameter int FLAG_W = 16
) (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RST,
  // AHB-Lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // Master identity, qualified with the address phase
  input wire logic CORE_MASTER,
  // Requests
  output logic INT_REQ,
  output logic EXT_REQ_PIN_O,
  output logic EXT_REQ_PIN_OE
);
  initial begin
    if (FLAG_W < 1 || FLAG_W > 16) begin
      $error("friu_top: FLAG_W must be 1 to 16");
    end
  end

  friu_pkg::friu_phase_type phase_r;
  logic [13:0] addr_r;
  logic word_r;
  logic core_r;
  logic [31:0] hrdata_r;
  logic hreadyout_r;
  logic [FLAG_W-1:0] polarity_r;
  logic [FLAG_W-1:0] int_mask_r;
  logic [FLAG_W-1:0] ext_mask_r;
  logic pin_driver_r;
  logic ext_invert_r;
  logic int_invert_r;
  logic int_req_r;
  logic pin_o_r;
  logic pin_oe_r;
  logic [FLAG_W-1:0] flags;
  logic accept;
  logic wr_go;
  logic [FLAG_W-1:0] wdata;
  logic [FLAG_W-1:0] per_flag_req;
  logic int_level;
  logic ext_level;

  // Word index match against a register byte address
  function automatic logic hit(input logic [13:0] idx, input logic [15:0] ofs);
    hit = (idx == ofs[15:2]);
  endfunction

  // Zero-extend a flag-wide field to a bus word
  function automatic logic [31:0] widen(input logic [FLAG_W-1:0] v);
    widen = 32'h0000_0000;
    widen[FLAG_W-1:0] = v;
  endfunction

  assign accept = HSEL && HREADY && HTRANS[1];
  assign wr_go = (phase_r == friu_pkg::ST_WRITE) && word_r;
  assign wdata = HWDATA[FLAG_W-1:0];

  // Bus phase tracking
  always_ff @(posedge MCLK) begin
    if (RST) begin
      phase_r <= friu_pkg::ST_IDLE;
    end else begin
      unique case (phase_r)
        friu_pkg::ST_READ: begin
          phase_r <= friu_pkg::ST_READ_DONE;
        end
        friu_pkg::ST_IDLE, friu_pkg::ST_WRITE, friu_pkg::ST_READ_DONE: begin
          if (accept) begin
            phase_r <= HWRITE ? friu_pkg::ST_WRITE : friu_pkg::ST_READ;
          end else begin
            phase_r <= friu_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  // Address phase capture
  always_ff @(posedge MCLK) begin
    if (RST) begin
      addr_r <= 14'h0000;
      word_r <= 1'h0;
      core_r <= 1'h0;
    end else if (accept) begin
      addr_r <= HADDR[15:2];
      word_r <= (HSIZE == friu_pkg::HSIZE_WORD);
      core_r <= CORE_MASTER;
    end
  end

  // Reads take one wait state so data comes from a register
  always_ff @(posedge MCLK) begin
    if (RST) begin
      hreadyout_r <= 1'h1;
    end else if (accept && !HWRITE) begin
      hreadyout_r <= 1'h0;
    end else if (phase_r == friu_pkg::ST_READ) begin
      hreadyout_r <= 1'h1;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      hrdata_r <= 32'h0000_0000;
    end else if (phase_r == friu_pkg::ST_READ) begin
      hrdata_r <= 32'h0000_0000;
      if (hit(addr_r, friu_pkg::OFS_FLAGS_DIRECT)) begin
        hrdata_r <= widen(flags);
      end
      if (hit(addr_r, friu_pkg::OFS_FLAGS_SET_CLEAR)) begin
        hrdata_r <= widen(flags);
      end
      if (hit(addr_r, friu_pkg::OFS_FLAG_POLARITY)) begin
        hrdata_r <= widen(polarity_r);
      end
      if (hit(addr_r, friu_pkg::OFS_OUTPUT_CONTROL)) begin
        hrdata_r[friu_pkg::POS_PIN_DRIVER] <= pin_driver_r;
        hrdata_r[friu_pkg::POS_EXTERNAL_INVERT] <= ext_invert_r;
        hrdata_r[friu_pkg::POS_INTERNAL_INVERT] <= int_invert_r;
      end
      if (hit(addr_r, friu_pkg::OFS_INTERNAL_MASK)) begin
        hrdata_r <= widen(int_mask_r);
      end
      if (hit(addr_r, friu_pkg::OFS_EXTERNAL_MASK)) begin
        hrdata_r <= widen(ext_mask_r);
      end
    end
  end

  friu_flag_bank #(
    .WIDTH(FLAG_W)
  ) u_flags (
    .clk(MCLK),
    .rst(RST),
    .wr_direct(wr_go && hit(addr_r, friu_pkg::OFS_FLAGS_DIRECT)),
    .wr_set_clear(wr_go && hit(addr_r, friu_pkg::OFS_FLAGS_SET_CLEAR)),
    .from_core(core_r),
    .wdata(wdata),
    .flags(flags)
  );

  always_ff @(posedge MCLK) begin
    if (RST) begin
      polarity_r <= FLAG_W'(friu_pkg::RST_POLARITY);
    end else if (wr_go && hit(addr_r, friu_pkg::OFS_FLAG_POLARITY)) begin
      polarity_r <= wdata;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      pin_driver_r <= friu_pkg::RST_PIN_DRIVER;
      ext_invert_r <= friu_pkg::RST_EXTERNAL_INVERT;
      int_invert_r <= friu_pkg::RST_INTERNAL_INVERT;
    end else if (wr_go && hit(addr_r, friu_pkg::OFS_OUTPUT_CONTROL)) begin
      pin_driver_r <= HWDATA[friu_pkg::POS_PIN_DRIVER];
      ext_invert_r <= HWDATA[friu_pkg::POS_EXTERNAL_INVERT];
      int_invert_r <= HWDATA[friu_pkg::POS_INTERNAL_INVERT];
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      int_mask_r <= FLAG_W'(friu_pkg::RST_MASK);
    end else if (wr_go && hit(addr_r, friu_pkg::OFS_INTERNAL_MASK)) begin
      int_mask_r <= wdata;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      ext_mask_r <= FLAG_W'(friu_pkg::RST_MASK);
    end else if (wr_go && hit(addr_r, friu_pkg::OFS_EXTERNAL_MASK)) begin
      ext_mask_r <= wdata;
    end
  end

  // Request path
  assign per_flag_req = flags ^ polarity_r;
  assign int_level = (|(per_flag_req & int_mask_r)) ^ int_invert_r;
  assign ext_level = (|(per_flag_req & ext_mask_r)) ^ ext_invert_r;

  // Reset constants match the request path with all masks clear
  always_ff @(posedge MCLK) begin
    if (RST) begin
      int_req_r <= 1'h1;
    end else begin
      int_req_r <= int_level;
    end
  end

  // Open drain pulls only low and releases for a high level
  always_ff @(posedge MCLK) begin
    if (RST) begin
      pin_o_r <= 1'h0;
      pin_oe_r <= 1'h0;
    end else if (pin_driver_r) begin
      pin_o_r <= ext_level;
      pin_oe_r <= 1'h1;
    end else begin
      pin_o_r <= 1'h0;
      pin_oe_r <= !ext_level;
    end
  end

  assign HRDATA = hrdata_r;
  assign HREADYOUT = hreadyout_r;
  assign HRESP = friu_pkg::HRESP_OKAY;
  assign INT_REQ = int_req_r;
  assign EXT_REQ_PIN_O = pin_o_r;
  assign EXT_REQ_PIN_OE = pin_oe_r;
endmodule
`default_nettype wire

/* friu_pkg.sv */
package friu_pkg;
  // Register byte addresses (low 16 bits of the bus address)
  localparam logic [15:0] OFS_FLAGS_DIRECT = 16'hF510;
  localparam logic [15:0] OFS_FLAGS_SET_CLEAR = 16'hF514;
  localparam logic [15:0] OFS_FLAG_POLARITY = 16'hF518;
  localparam logic [15:0] OFS_OUTPUT_CONTROL = 16'hF51C;
  localparam logic [15:0] OFS_INTERNAL_MASK = 16'hF520;
  localparam logic [15:0] OFS_EXTERNAL_MASK = 16'hF524;

  // Output control field positions
  localparam int POS_INTERNAL_INVERT = 0;
  localparam int POS_EXTERNAL_INVERT = 1;
  localparam int POS_PIN_DRIVER = 2;

  // Values after reset
  localparam logic [15:0] RST_FLAGS = 16'h0000;
  localparam logic [15:0] RST_POLARITY = 16'h0000;
  localparam logic [15:0] RST_MASK = 16'h0000;
  localparam logic RST_PIN_DRIVER = 1'h0;
  localparam logic RST_EXTERNAL_INVERT = 1'h1;
  localparam logic RST_INTERNAL_INVERT = 1'h1;

  // AHB encodings
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic HRESP_OKAY = 1'h0;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WRITE,
    ST_READ,
    ST_READ_DONE
  } friu_phase_type;
endpackage

/* friu_flag_bank.sv */
`timescale 1ns/100ps
`default_nettype none
module friu_flag_bank #(
  parameter int WIDTH = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic wr_direct,
  input wire logic wr_set_clear,
  input wire logic from_core,
  input wire logic [WIDTH-1:0] wdata,
  output logic [WIDTH-1:0] flags
);
  initial begin
    if (WIDTH < 1 || WIDTH > 32) begin
      $error("friu_flag_bank: WIDTH must be 1 to 32");
    end
  end

  logic [WIDTH-1:0] flags_r;
  logic [WIDTH-1:0] flags_nxt;

  // One storage behind both views, so each view sees the other's changes
  always_comb begin
    flags_nxt = flags_r;
    if (wr_direct) begin
      flags_nxt = wdata;
    end else if (wr_set_clear && from_core) begin
      flags_nxt = flags_r | wdata;
    end else if (wr_set_clear) begin
      flags_nxt = flags_r & ~wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      flags_r <= WIDTH'(friu_pkg::RST_FLAGS);
    end else begin
      flags_r <= flags_nxt;
    end
  end

  assign flags = flags_r;
endmodule
`default_nettype wire

/* friu_top_chk.sv */
`timescale 1ns/100ps
`default_nettype none
module friu_chk (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RST,
  // Bus
  input wire logic HSEL,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  // Requests
  input wire logic INT_REQ,
  input wire logic EXT_REQ_PIN_O,
  input wire logic EXT_REQ_PIN_OE
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (RST);
  wire logic take = HSEL && HREADY && HTRANS[1];
  a_resp_okay: assert property (HRESP == 1'h0)
    else $error("response not okay");
  a_read_wait: assert property (take && !HWRITE |=> !HREADYOUT ##1 HREADYOUT)
    else $error("read wait wrong");
  a_write_nowait: assert property (take && HWRITE |=> HREADYOUT)
    else $error("write stalled");
  a_od_release: assert property (!EXT_REQ_PIN_OE |-> !EXT_REQ_PIN_O)
    else $error("released pin not low");
  a_rst_int: assert property ($fell(RST) |-> INT_REQ)
    else $error("internal request after reset");
  a_rst_pin: assert property ($fell(RST) |-> !EXT_REQ_PIN_OE && !EXT_REQ_PIN_O)
    else $error("pin after reset");
  a_rdata_hold: assert property (HREADYOUT && $past(HREADYOUT) |-> $stable(HRDATA))
    else $error("read data moved");
  a_upper_zero: assert property (HRDATA[31:16] == 16'h0000)
    else $error("upper bits set");
endmodule
bind friu_top friu_chk i_chk (.MCLK, .RST, .HSEL, .HTRANS, .HWRITE, .HREADY, .HRDATA,
  .HREADYOUT, .HRESP, .INT_REQ, .EXT_REQ_PIN_O, .EXT_REQ_PIN_OE);
`default_nettype wire

/* friu_pin_model.sv */
`timescale 1ns/100ps
`default_nettype none
module friu_pin_model (
  // Pin driver
  input wire logic o,
  input wire logic oe,
  // Board level
  output logic pin
);
  // Released pin sits at the pull-up level
  assign pin = oe ? o : 1'h1;
endmodule
`default_nettype wire

/* tb_flag_interrupt_request_unit.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_flag_interrupt_request_unit;
  logic mclk = 0, rst = 1, hsel = 0, hwrite = 0, core = 1;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = friu_pkg::HSIZE_WORD;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, q;
  wire logic [31:0] hrdata;
  wire logic hready, hresp, int_req, pin_o, pin_oe, pin;
  int err_total = 0, n_checks = 0;
  initial forever #5 mclk = ~mclk;
  friu_top i_dut (.MCLK(mclk), .RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready),
    .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp), .CORE_MASTER(core),
    .INT_REQ(int_req), .EXT_REQ_PIN_O(pin_o), .EXT_REQ_PIN_OE(pin_oe));
  friu_pin_model i_pin (.o(pin_o), .oe(pin_oe), .pin(pin));
  task automatic cmp(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic xfer(input logic [15:0] a, input logic w, input logic [31:0] d,
    input logic c);
    hsel <= 1'h1;
    haddr <= {16'h0000, a};
    hwrite <= w;
    core <= c;
    htrans <= 2'h2;
    // Ready is sampled at the rising edge, before the design updates it
    do @(posedge mclk); while (hready !== 1'h1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hready !== 1'h1);
    q = hrdata;
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic c);
    xfer(a, 1'h1, d, c);
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] e);
    xfer(a, 1'h0, 32'h0, 1'h1);
    cmp(q, e);
  endtask
  // Outputs follow a register change one cycle late
  task automatic req(input logic ei, input logic el, input logic t);
    repeat (2) @(negedge mclk);
    cmp({31'h0, int_req}, {31'h0, ei});
    cmp({31'h0, pin}, {31'h0, el});
    cmp({31'h0, pin_oe}, {31'h0, t | ~el});
    @(posedge mclk);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #50000;
    err_total++;
    end_of_test();
  end
  initial begin
    repeat (10) @(posedge mclk);
    rst <= 1'h0;
    @(posedge mclk);
    for (int i = 0; i < 7; i++) begin
      rd(16'hF510 + 16'(4 * i), (i == 3) ? 32'h3 : 32'h0);
    end
    req(1'h1, 1'h1, 1'h0);
    wr(16'hF528, 32'hFFFFFFFF, 1'h1);
    rd(16'hF528, 32'h0);
    $display("test reset done");
    wr(16'hF510, 32'hFFFFFFFF, 1'h0);
    wr(16'hF510, 32'hFFFFA5C3, 1'h1);
    rd(16'hF514, 32'h0000A5C3);
    wr(16'hF514, 32'h00000F00, 1'h1);
    rd(16'hF510, 32'h0000AFC3);
    wr(16'hF514, 32'h000000C3, 1'h0);
    rd(16'hF514, 32'h0000AF00);
    rd(16'hF514, 32'h0000AF00);
    $display("test flags done");
    // A byte-sized write must leave the mask untouched
    hsize <= 3'h0;
    wr(16'hF520, 32'h0000FFFF, 1'h1);
    hsize <= friu_pkg::HSIZE_WORD;
    rd(16'hF520, 32'h0);
    wr(16'hF520, 32'h00000100, 1'h1);
    req(1'h0, 1'h1, 1'h0);
    wr(16'hF51C, 32'h0, 1'h1);
    rd(16'hF51C, 32'h0);
    req(1'h1, 1'h0, 1'h0);
    wr(16'hF518, 32'h00000001, 1'h1);
    wr(16'hF524, 32'h00000001, 1'h1);
    req(1'h1, 1'h1, 1'h0);
    wr(16'hF51C, 32'h4, 1'h1);
    req(1'h1, 1'h1, 1'h1);
    wr(16'hF51C, 32'h7, 1'h1);
    req(1'h0, 1'h0, 1'h1);
    wr(16'hF514, 32'h00000100, 1'h0);
    req(1'h1, 1'h0, 1'h1);
    $display("test requests done");
    rst <= 1'h1;
    repeat (2) @(posedge mclk);
    rst <= 1'h0;
    @(posedge mclk);
    rd(16'hF510, 32'h0);
    rd(16'hF51C, 32'h3);
    $display("test second reset done");
    end_of_test();
  end
endmodule
`default_nettype wire
